// ===== adch_cmd.sv
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Words 84, 87 read 4000h; 86 reads 0000h.
// - Word 85 support flags fixed as listed.
// - Word 85 enable bits follow current settings.
// - Word 127 bit 8 shows write protect.
// - Word 127 low bits 01; others zero.
// - Opcode A0h accepts packet when drive selected.
// - Opcode 80h sets busy and pulses internal reset in the same cycle.
// - Reset end clears busy, no interrupt.
// - Opcodes 98h, E5h load power code.
// - Standby states 00h; idle, active FFh.
// - Sleep mode ignores all commands.
// - Diagnostic runs regardless of drive select.
// - Device 0 alone reports 01h.
// - Device 0 waits six seconds for pass.
// - Device 1 timeout ORs 80h into code.
// - Device 1 failure sets check bit.
// - Device 1 asserts pass, reports 01h.
// - Diagnostic codes 01h and 81h only.
module adch_cmd #(
    parameter int unsigned DIAG_WAIT_CYCLES = adch_pkg::DIAG_WAIT_CYC,
    parameter int unsigned RESET_CYCLES     = adch_pkg::RESET_CYC
) (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        cmd_wr,
    input  wire logic [7:0]  command_reg,
    input  wire logic [7:0]  drive_head_reg,
    input  wire logic        status_rd,
    input  wire logic        is_device1,
    input  wire logic        device1_present,
    input  wire logic        sleep_mode,
    input  wire logic [2:0]  power_state,
    input  wire logic        passed_diagnostic_n_in,
    input  wire logic [7:0]  ident_addr,
    input  wire logic        write_protect,
    input  wire logic        svc_int_en,
    input  wire logic        rel_int_en,
    input  wire logic        read_ahead_en,
    input  wire logic        write_cache_en,
    output logic             passed_diagnostic_n_out,
    output logic             passed_diagnostic_n_oe,
    output logic             busy,
    output logic             check,
    output logic             intrq,
    output logic      [7:0]  error_reg,
    output logic      [7:0]  sector_count_reg,
    output logic             packet_accept,
    output logic             reset_pulse,
    output logic      [15:0] ident_data
);

    typedef struct packed {
        adch_pkg::adch_state_t st;
        logic                  bsy;
        logic                  chk;
        logic                  irq;
        logic [7:0]            err;
        logic [7:0]            sc;
        logic                  passed_diagnostic_n;
        logic                  pkt;
        logic                  rst_p;
    } adch_regs_t;

    adch_regs_t s_r;
    adch_regs_t s_nxt;
    logic       selected;
    logic       accept;
    logic       tmr_load;
    logic       tmr_abort;
    logic [31:0] tmr_val;
    logic       tmr_expired;
    logic [7:0] pwr_code;

    // ------------------------------------------------------------------
    // Command acceptance
    // ------------------------------------------------------------------
    assign selected = drive_head_reg[adch_pkg::DRV_BIT] == is_device1;
    assign accept = cmd_wr && !sleep_mode && !s_r.bsy
        && s_r.st == adch_pkg::ST_IDLE;

    always_comb begin
        if (power_state == adch_pkg::PM_IDLE
            || power_state == adch_pkg::PM_ACTIVE) begin
            pwr_code = adch_pkg::PWR_CODE_RUN;
        end else begin
            pwr_code = adch_pkg::PWR_CODE_SBY;
        end
    end

    // ------------------------------------------------------------------
    // Main sequencer
    // ------------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.pkt = 1'b0;
        s_nxt.rst_p = 1'b0;
        tmr_load = 1'b0;
        tmr_abort = 1'b0;
        tmr_val = 32'h0000_0000;
        if (status_rd) begin
            s_nxt.irq = 1'b0;
        end
        case (s_r.st)
            adch_pkg::ST_IDLE: begin
                if (accept) begin
                    if (command_reg == adch_pkg::OP_DIAG) begin
                        s_nxt.bsy = 1'b1;
                        s_nxt.chk = 1'b0;
                        s_nxt.irq = 1'b0;
                        s_nxt.passed_diagnostic_n = is_device1;
                        if (!is_device1 && device1_present) begin
                            s_nxt.st = adch_pkg::ST_DIAG_WAIT;
                            tmr_load = 1'b1;
                            tmr_val = DIAG_WAIT_CYCLES;
                        end else begin
                            s_nxt.st = adch_pkg::ST_DIAG_DONE;
                        end
                    end else if (selected
                        && command_reg == adch_pkg::OP_DEV_RESET) begin
                        s_nxt.bsy = 1'b1;
                        s_nxt.irq = 1'b0;
                        s_nxt.rst_p = 1'b1;
                        s_nxt.st = adch_pkg::ST_RESET;
                        tmr_load = 1'b1;
                        tmr_val = RESET_CYCLES;
                    end else if (selected
                        && (command_reg == adch_pkg::OP_PWR_A
                        || command_reg == adch_pkg::OP_PWR_B)) begin
                        s_nxt.bsy = 1'b1;
                        s_nxt.irq = 1'b0;
                        s_nxt.st = adch_pkg::ST_PWR;
                    end else if (selected
                        && command_reg == adch_pkg::OP_PACKET) begin
                        s_nxt.pkt = 1'b1;
                        s_nxt.irq = 1'b0;
                    end
                end
            end
            adch_pkg::ST_RESET: begin
                if (tmr_expired) begin
                    s_nxt.bsy = 1'b0;
                    s_nxt.chk = 1'b0;
                    s_nxt.passed_diagnostic_n = 1'b0;
                    s_nxt.st = adch_pkg::ST_IDLE;
                end
            end
            adch_pkg::ST_PWR: begin
                s_nxt.sc = pwr_code;
                s_nxt.bsy = 1'b0;
                s_nxt.irq = 1'b1;
                s_nxt.st = adch_pkg::ST_IDLE;
            end
            adch_pkg::ST_DIAG_DONE: begin
                s_nxt.err = adch_pkg::DIAG_OK;
                s_nxt.bsy = 1'b0;
                s_nxt.irq = 1'b1;
                s_nxt.st = adch_pkg::ST_IDLE;
            end
            adch_pkg::ST_DIAG_WAIT: begin
                if (!passed_diagnostic_n_in) begin
                    tmr_abort = 1'b1;
                    s_nxt.err = adch_pkg::DIAG_OK;
                    s_nxt.bsy = 1'b0;
                    s_nxt.irq = 1'b1;
                    s_nxt.st = adch_pkg::ST_IDLE;
                end else if (tmr_expired) begin
                    s_nxt.err = adch_pkg::DIAG_OK
                        | adch_pkg::DIAG_DEV1_NG;
                    s_nxt.chk = 1'b1;
                    s_nxt.bsy = 1'b0;
                    s_nxt.irq = 1'b1;
                    s_nxt.st = adch_pkg::ST_IDLE;
                end
            end
            default: begin
                s_nxt.st = adch_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_r.st    <= adch_pkg::ST_IDLE;
            s_r.bsy   <= 1'b0;
            s_r.chk   <= 1'b0;
            s_r.irq   <= 1'b0;
            s_r.err   <= adch_pkg::DIAG_OK;
            s_r.sc    <= 8'h00;
            s_r.passed_diagnostic_n <= 1'b0;
            s_r.pkt   <= 1'b0;
            s_r.rst_p <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    adch_timer u_timer (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .load     (tmr_load),
        .abort    (tmr_abort),
        .load_val (tmr_val),
        .expired  (tmr_expired)
    );

    adch_ident u_ident (
        .ref_clk        (ref_clk),
        .rst            (rst),
        .word_addr      (ident_addr),
        .write_protect  (write_protect),
        .svc_int_en     (svc_int_en),
        .rel_int_en     (rel_int_en),
        .read_ahead_en  (read_ahead_en),
        .write_cache_en (write_cache_en),
        .word_data      (ident_data)
    );

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign passed_diagnostic_n_out = 1'b0;
    assign passed_diagnostic_n_oe  = s_r.passed_diagnostic_n;
    assign busy             = s_r.bsy;
    assign check            = s_r.chk;
    assign intrq            = s_r.irq;
    assign error_reg        = s_r.err;
    assign sector_count_reg = s_r.sc;
    assign packet_accept    = s_r.pkt;
    assign reset_pulse      = s_r.rst_p;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_reset_busy_set: assert property (@(posedge ref_clk)
        disable iff (rst)
        accept && selected && command_reg == adch_pkg::OP_DEV_RESET
            |=> busy && reset_pulse)
        else $error("device reset did not raise busy");

    a_reset_end_quiet: assert property (@(posedge ref_clk)
        disable iff (rst)
        s_r.st == adch_pkg::ST_RESET && tmr_expired
            |=> !busy && !intrq)
        else $error("reset end wrong busy or interrupt");

    a_power_code: assert property (@(posedge ref_clk)
        disable iff (rst)
        s_r.st == adch_pkg::ST_PWR |=>
            sector_count_reg == (($past(power_state) == adch_pkg::PM_IDLE
            || $past(power_state) == adch_pkg::PM_ACTIVE) ? 8'hff : 8'h00)
            && !busy)
        else $error("power mode code wrong");

    a_power_query: assert property (@(posedge ref_clk)
        disable iff (rst)
        accept && selected && command_reg == adch_pkg::OP_PWR_B
            |=> busy ##1 !busy && intrq)
        else $error("power query not answered in two cycles");

    a_sleep_ignore: assert property (@(posedge ref_clk)
        disable iff (rst)
        sleep_mode && !busy && !status_rd |=> !busy && !packet_accept)
        else $error("command accepted in sleep");

    a_packet_accept: assert property (@(posedge ref_clk)
        disable iff (rst)
        packet_accept |-> $past(cmd_wr) && $past(command_reg) == 8'ha0
            && $past(drive_head_reg[4]) == $past(is_device1))
        else $error("packet accepted without selected write");

    a_diag_alone: assert property (@(posedge ref_clk)
        disable iff (rst)
        accept && command_reg == adch_pkg::OP_DIAG && !is_device1
            && !device1_present |=> busy ##1 error_reg == 8'h01 && !check)
        else $error("lone device 0 diagnostic wrong");

    a_dev1_pass: assert property (@(posedge ref_clk)
        disable iff (rst)
        accept && command_reg == adch_pkg::OP_DIAG && is_device1
            |=> passed_diagnostic_n_oe ##1 error_reg == 8'h01 && !busy)
        else $error("device 1 diagnostic wrong");

    a_dev1_fail: assert property (@(posedge ref_clk)
        disable iff (rst)
        s_r.st == adch_pkg::ST_DIAG_WAIT && passed_diagnostic_n_in
            && tmr_expired |=> error_reg == 8'h81 && check && !busy)
        else $error("device 1 failure not reported");

    a_diag_any_drv: assert property (@(posedge ref_clk)
        disable iff (rst)
        accept && command_reg == adch_pkg::OP_DIAG |=> busy
            && s_r.st != adch_pkg::ST_IDLE)
        else $error("diagnostic refused for drive select");

    a_busy_held: assert property (@(posedge ref_clk)
        disable iff (rst) s_r.st != adch_pkg::ST_IDLE |-> busy)
        else $error("busy dropped before result");

    a_power_query_a: assert property (@(posedge ref_clk)
        disable iff (rst)
        accept && selected && command_reg == adch_pkg::OP_PWR_A
            |=> busy ##1 !busy && intrq)
        else $error("power query 98h not answered");

    a_dev0_pass_seen: assert property (@(posedge ref_clk)
        disable iff (rst)
        s_r.st == adch_pkg::ST_DIAG_WAIT && !passed_diagnostic_n_in
            |=> error_reg == 8'h01 && !check && !busy)
        else $error("device 1 pass not honoured");

    a_dev0_listens: assert property (@(posedge ref_clk)
        disable iff (rst)
        s_r.st == adch_pkg::ST_DIAG_WAIT |-> !passed_diagnostic_n_oe)
        else $error("device 0 drives pass line");

    a_check_fail_code: assert property (@(posedge ref_clk)
        disable iff (rst) $rose(check) |-> error_reg[7])
        else $error("check set without device 1 failure");

    a_reset_irq_quiet: assert property (@(posedge ref_clk)
        disable iff (rst) s_r.st == adch_pkg::ST_RESET |-> !intrq)
        else $error("interrupt during device reset");

    a_busy_refuses: assert property (@(posedge ref_clk)
        disable iff (rst) cmd_wr && busy
            |=> !packet_accept && !reset_pulse)
        else $error("command taken while busy");

    a_sleep_no_pulse: assert property (@(posedge ref_clk)
        disable iff (rst) cmd_wr && sleep_mode
            |=> !packet_accept && !reset_pulse)
        else $error("command taken in sleep");

    a_unselected_quiet: assert property (@(posedge ref_clk)
        disable iff (rst)
        cmd_wr && !busy && !selected && command_reg != adch_pkg::OP_DIAG
            |=> !busy && !packet_accept && !reset_pulse)
        else $error("unselected command taken");

    a_packet_idle: assert property (@(posedge ref_clk)
        disable iff (rst) packet_accept |-> !busy)
        else $error("packet accepted while busy");

endmodule : adch_cmd
`default_nettype wire

// ===== adch_pkg.sv
package adch_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ          = 10_000_000;
    localparam int unsigned DIAG_WAIT_S     = 6;
    localparam int unsigned DIAG_WAIT_CYC   = DIAG_WAIT_S * CLK_HZ;
    localparam int unsigned PASSED_DIAGNOSTIC_N_MAX_S     = 5;
    localparam int unsigned PASSED_DIAGNOSTIC_N_MAX_CYC   = PASSED_DIAGNOSTIC_N_MAX_S * CLK_HZ;
    localparam int unsigned RESET_TIME_US   = 10;
    localparam int unsigned RESET_CYC       =
        (RESET_TIME_US * (CLK_HZ / 1_000_000) < 1) ? 1 :
        RESET_TIME_US * (CLK_HZ / 1_000_000);

    // ------------------------------------------------------------------
    // Opcodes and register fields
    // ------------------------------------------------------------------
    localparam logic [7:0] OP_PACKET    = 8'ha0;
    localparam logic [7:0] OP_DEV_RESET = 8'h80;
    localparam logic [7:0] OP_PWR_A     = 8'h98;
    localparam logic [7:0] OP_PWR_B     = 8'he5;
    localparam logic [7:0] OP_DIAG      = 8'h90;
    localparam int unsigned DRV_BIT     = 4;

    // ------------------------------------------------------------------
    // Diagnostic and power mode codes
    // ------------------------------------------------------------------
    localparam logic [7:0] DIAG_OK      = 8'h01;
    localparam logic [7:0] DIAG_DEV1_NG = 8'h80;
    localparam logic [7:0] PWR_CODE_SBY = 8'h00;
    localparam logic [7:0] PWR_CODE_RUN = 8'hff;
    localparam logic [2:0] PM_STANDBY   = 3'h0;
    localparam logic [2:0] PM_ENT_SBY   = 3'h1;
    localparam logic [2:0] PM_RET_SBY   = 3'h2;
    localparam logic [2:0] PM_IDLE      = 3'h3;
    localparam logic [2:0] PM_ACTIVE    = 3'h4;

    // ------------------------------------------------------------------
    // Identify words
    // ------------------------------------------------------------------
    localparam logic [7:0]  W84        = 8'h54;
    localparam logic [7:0]  W85        = 8'h55;
    localparam logic [7:0]  W86        = 8'h56;
    localparam logic [7:0]  W87        = 8'h57;
    localparam logic [7:0]  W127       = 8'h7f;
    localparam logic [15:0] W84_VAL    = 16'h4000;
    localparam logic [15:0] W86_VAL    = 16'h0000;
    localparam logic [15:0] W87_VAL    = 16'h4000;
    localparam logic [15:0] W85_FIXED  = 16'h4218;
    localparam int unsigned W85_SVC    = 8;
    localparam int unsigned W85_REL    = 7;
    localparam int unsigned W85_RA     = 6;
    localparam int unsigned W85_WC     = 5;
    localparam logic [15:0] W127_FIXED = 16'h0001;
    localparam int unsigned W127_WP    = 8;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RESET,
        ST_PWR,
        ST_DIAG_DONE,
        ST_DIAG_WAIT
    } adch_state_t;

endpackage : adch_pkg

// ===== adch_timer.sv
`timescale 1ns/10ps
`default_nettype none
module adch_timer (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        load,
    input  wire logic        abort,
    input  wire logic [31:0] load_val,
    output logic             expired
);

    typedef struct packed {
        logic [31:0] cnt;
        logic        run;
        logic        expired;
    } adch_tmr_t;

    adch_tmr_t s_r;
    adch_tmr_t s_nxt;

    // ------------------------------------------------------------------
    // Countdown: expired pulses load_val edges after the load edge.
    // ------------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.expired = 1'b0;
        if (load) begin
            s_nxt.cnt = load_val;
            s_nxt.run = 1'b1;
        end else if (abort) begin
            s_nxt.run = 1'b0;
        end else if (s_r.run) begin
            if (s_r.cnt <= 32'h0000_0001) begin
                s_nxt.run = 1'b0;
                s_nxt.expired = 1'b1;
            end else begin
                s_nxt.cnt = s_r.cnt - 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign expired = s_r.expired;

endmodule : adch_timer
`default_nettype wire

// ===== adch_ident.sv
`timescale 1ns/10ps
`default_nettype none
module adch_ident (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic [7:0]  word_addr,
    input  wire logic        write_protect,
    input  wire logic        svc_int_en,
    input  wire logic        rel_int_en,
    input  wire logic        read_ahead_en,
    input  wire logic        write_cache_en,
    output logic      [15:0] word_data
);

    typedef struct packed {
        logic [15:0] data;
    } adch_id_t;

    adch_id_t s_r;
    adch_id_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (word_addr == adch_pkg::W84) begin
            s_nxt.data = adch_pkg::W84_VAL;
        end else if (word_addr == adch_pkg::W86) begin
            s_nxt.data = adch_pkg::W86_VAL;
        end else if (word_addr == adch_pkg::W87) begin
            s_nxt.data = adch_pkg::W87_VAL;
        end else if (word_addr == adch_pkg::W85) begin
            s_nxt.data = adch_pkg::W85_FIXED;
            s_nxt.data[adch_pkg::W85_SVC] = svc_int_en;
            s_nxt.data[adch_pkg::W85_REL] = rel_int_en;
            s_nxt.data[adch_pkg::W85_RA] = read_ahead_en;
            s_nxt.data[adch_pkg::W85_WC] = write_cache_en;
        end else if (word_addr == adch_pkg::W127) begin
            s_nxt.data = adch_pkg::W127_FIXED;
            s_nxt.data[adch_pkg::W127_WP] = write_protect;
        end else begin
            s_nxt.data = 16'h0000;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign word_data = s_r.data;

    a_word85_value: assert property (@(posedge ref_clk)
        disable iff (rst)
        word_addr == adch_pkg::W85 |=> word_data[15:9] == 7'h21
            && word_data[4:0] == 5'h18)
        else $error("word 85 support flags wrong");

    a_word127_wp: assert property (@(posedge ref_clk)
        disable iff (rst)
        word_addr == adch_pkg::W127 |=>
            word_data == {7'h00, $past(write_protect), 8'h01})
        else $error("word 127 value wrong");

endmodule : adch_ident
`default_nettype wire

// ===== adch_peer_dev1.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------------
// Second unit on the cable, seen only through the open-drain pass line.
// ----------------------------------------------------------------------
module adch_peer_dev1 (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       cmd_wr,
    input  wire logic [7:0] command_reg,
    input  wire logic       respond,
    input  wire logic [7:0] delay_cyc,
    output logic            pass_oe
);
    logic [7:0] cnt_r;
    logic       run_r;

    // A silent unit never pulls the line, so the first unit must time out.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_r   <= 8'h00;
            run_r   <= 1'b0;
            pass_oe <= 1'b0;
        end else if (cmd_wr && command_reg == adch_pkg::OP_DIAG) begin
            cnt_r   <= delay_cyc;
            run_r   <= respond;
            pass_oe <= 1'b0;
        end else if (run_r && cnt_r == 8'h00) begin
            run_r   <= 1'b0;
            pass_oe <= 1'b1;
        end else if (run_r) begin
            cnt_r <= cnt_r - 8'h01;
        end
    end
endmodule : adch_peer_dev1
`default_nettype wire

// ===== adch_cmd_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module adch_cmd_tb_top;
    localparam int unsigned DWAIT = 50;
    localparam int unsigned RCYC  = 4;

    logic        ref_clk, rst, cmd_wr, status_rd, is_device1;
    logic        device1_present, sleep_mode, write_protect, svc_int_en;
    logic        rel_int_en, read_ahead_en, write_cache_en, respond;
    logic [7:0]  command_reg, drive_head_reg, ident_addr;
    logic [2:0]  power_state;
    logic        pd_out, pd_oe, peer_oe, busy, check, intrq;
    logic        packet_accept, reset_pulse;
    logic [7:0]  error_reg, sector_count_reg;
    logic [15:0] ident_data;
    wire         pass_line_n;
    int          num_errors, tests_run;

    // The pass line has a pull-up; either unit may pull it low.
    assign pass_line_n = ~(pd_oe | peer_oe);

    adch_cmd #(.DIAG_WAIT_CYCLES(DWAIT), .RESET_CYCLES(RCYC)) dut (
        .ref_clk(ref_clk), .rst(rst), .cmd_wr(cmd_wr),
        .command_reg(command_reg), .drive_head_reg(drive_head_reg),
        .status_rd(status_rd), .is_device1(is_device1),
        .device1_present(device1_present), .sleep_mode(sleep_mode),
        .power_state(power_state), .passed_diagnostic_n_in(pass_line_n),
        .ident_addr(ident_addr), .write_protect(write_protect),
        .svc_int_en(svc_int_en), .rel_int_en(rel_int_en),
        .read_ahead_en(read_ahead_en), .write_cache_en(write_cache_en),
        .passed_diagnostic_n_out(pd_out), .passed_diagnostic_n_oe(pd_oe),
        .busy(busy), .check(check), .intrq(intrq), .error_reg(error_reg),
        .sector_count_reg(sector_count_reg),
        .packet_accept(packet_accept), .reset_pulse(reset_pulse),
        .ident_data(ident_data));

    adch_peer_dev1 peer (
        .ref_clk(ref_clk), .rst(rst), .cmd_wr(cmd_wr),
        .command_reg(command_reg), .respond(respond),
        .delay_cyc(8'h0a), .pass_oe(peer_oe));

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    // ------------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------------
    task automatic end_sim();
        $display("errors=%0d compares=%0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : cyc

    task automatic issue(input logic [7:0] op, input logic [7:0] dh);
        cmd_wr         = 1'b1;
        command_reg    = op;
        drive_head_reg = dh;
        cyc(1);
        cmd_wr = 1'b0;
    endtask : issue

    task automatic wait_idle(input int lim);
        int k;
        k = 0;
        while (busy !== 1'b0 && k < lim) begin
            cyc(1);
            k++;
        end
        if (k >= lim) begin
            num_errors++;
            $display("MISMATCH t=%0t busy never cleared", $time);
            end_sim();
        end
    endtask : wait_idle

    task automatic id_chk(input logic [7:0] a, input logic [15:0] exp);
        ident_addr = a;
        cyc(1);
        chk(ident_data, exp);
    endtask : id_chk

    task automatic pwr(input logic [2:0] ps, input logic [7:0] op);
        power_state = ps;
        issue(op, 8'h00);
        chk(busy, 1'b1);
        cyc(1);
        chk(sector_count_reg, (ps < 3'h3) ? 8'h00 : 8'hff);
        chk({busy, intrq}, 2'h1);
        status_rd = 1'b1;
        cyc(1);
        status_rd = 1'b0;
        chk(intrq, 1'b0);
    endtask : pwr

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        {cmd_wr, status_rd, is_device1, device1_present, sleep_mode} = 5'h00;
        {write_protect, svc_int_en, rel_int_en, respond} = 4'h0;
        {read_ahead_en, write_cache_en} = 2'h3;
        command_reg    = 8'h00;
        drive_head_reg = 8'h00;
        ident_addr     = 8'h00;
        power_state    = 3'h4;
        num_errors     = 0;
        tests_run      = 0;
        rst            = 1'b1;
        repeat (10) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        chk({busy, check, intrq, error_reg}, {3'h0, 8'h01});
        id_chk(8'h54, 16'h4000);
        id_chk(8'h56, 16'h0000);
        id_chk(8'h57, 16'h4000);
        id_chk(8'h55, 16'h4278);
        {svc_int_en, rel_int_en, read_ahead_en, write_cache_en} = 4'hc;
        id_chk(8'h55, 16'h4398);
        id_chk(8'h7f, 16'h0001);
        write_protect = 1'b1;
        id_chk(8'h7f, 16'h0101);
        id_chk(8'h58, 16'h0000);
        id_chk(8'h7e, 16'h0000);
        id_chk(8'h80, 16'h0000);
        id_chk(8'hff, 16'h0000);
        for (int p = 4; p >= 0; p--) begin
            pwr(p[2:0], p[0] ? 8'h98 : 8'he5);
        end
        sleep_mode  = 1'b1;
        power_state = 3'h4;
        issue(8'h98, 8'h00);
        cyc(2);
        chk({busy, sector_count_reg}, 9'h000);
        sleep_mode = 1'b0;
        issue(8'h98, 8'h10);
        cyc(2);
        chk({busy, sector_count_reg}, 9'h000);
        issue(8'ha0, 8'h00);
        chk({packet_accept, busy}, 2'h2);
        cyc(1);
        chk(packet_accept, 1'b0);
        issue(8'h90, 8'h10);
        chk(busy, 1'b1);
        cyc(1);
        chk({busy, check, intrq, error_reg}, {3'h1, 8'h01});
        device1_present = 1'b1;
        respond         = 1'b1;
        issue(8'h90, 8'h00);
        wait_idle(20);
        chk({check, error_reg}, {1'b0, 8'h01});
        respond = 1'b0;
        issue(8'h90, 8'h00);
        cyc(DWAIT - 2);
        chk(busy, 1'b1);
        wait_idle(4);
        chk({check, error_reg}, {1'b1, 8'h81});
        issue(8'h80, 8'h00);
        chk({busy, reset_pulse, intrq}, 3'h6);
        cyc(1);
        issue(8'h98, 8'h00);
        cyc(RCYC - 2);
        chk({busy, sector_count_reg}, 9'h100);
        cyc(1);
        chk({busy, intrq, check}, 3'h0);
        is_device1 = 1'b1;
        issue(8'h90, 8'h00);
        chk({busy, pd_oe, pass_line_n, pd_out}, 4'hc);
        cyc(1);
        chk({busy, error_reg}, {1'b0, 8'h01});
        end_sim();
    end
endmodule : adch_cmd_tb_top
`default_nettype wire
